// ==== src/eeprom_ctl.sv ====
// Purpose: host controller driving a 1024x8 eeprom by its pins
// Assumes: one 100 MHz clock, synchronous active high reset
// Notes: pins use a data bus split into in, out and output enable (low = driving)
//
// Overview of operation
// - erase: strobe and drive high, raise voltage, pulse drive low.
// - erase may be timed by a select pulse with drive held low.
// - controller erases only on request; the host erases before rewriting written locations.
// - write: strobe and drive high, raise voltage, pulse strobe low.
// - address valid at strobe fall, data valid through strobe low.
// - writes may follow erase back to back with voltage held.
// - write may be timed by a select pulse with strobe held low.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_ctl_defines.svh"
module eeprom_ctl (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic req_valid_in,
  input wire eeprom_ctl_pkg::cmd_type req_cmd_in,
  input wire logic [`ADDR_W-1:0] req_addr_in,
  input wire logic [`DATA_W-1:0] req_data_in,
  input wire logic keep_voltage_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [`DATA_W-1:0] rsp_data_out,
  output logic device_select_out,
  output logic latch_strobe_n_out,
  output logic output_drive_n_out,
  output logic program_voltage_en_out,
  output logic [`ADDR_W-1:0] byte_addr_out,
  input wire logic [`DATA_W-1:0] data_in,
  output logic [`DATA_W-1:0] data_out,
  output logic data_oe_n_out
);
  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_VPP_SETUP,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD,
    ST_ACCESS,
    ST_RECOVER
  } state_type;

  state_type state_q, state_d;
  eeprom_ctl_pkg::cmd_type cmd_q, cmd_d;
  eeprom_ctl_pkg::pins_type pins_q, pins_d;
  logic [`CNT_W-1:0] cnt_q, cnt_d;
  logic [`ADDR_W-1:0] addr_q, addr_d;
  logic [`DATA_W-1:0] wdata_q, wdata_d;
  logic drive_q, drive_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [`DATA_W-1:0] rsp_data_q, rsp_data_d;
  logic [`DATA_W-1:0] rd_meta_q, rd_sync_q;
  logic vpp_on_q, vpp_on_d;
  // registered copies so ready and bus enable leave straight from flops
  logic ready_q, oe_n_q;

  // bus comes from off chip: two flops before anything reads it
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rd_meta_q <= '0;
      rd_sync_q <= '0;
    end else if (clk_en_in) begin
      rd_meta_q <= data_in;
      rd_sync_q <= rd_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire cnt_done = (cnt_q == '0);
  wire ready_d = (state_d == ST_IDLE);
  wire take_req = (state_q == ST_IDLE) && req_valid_in;
  wire req_prog = (req_cmd_in != eeprom_ctl_pkg::CMD_READ);
  // voltage may be left raised between operations to chain writes
  wire drop_vpp = vpp_on_q && !keep_voltage_in && !req_valid_in;

  function automatic logic [`CNT_W-1:0] cyc(input int n);
    cyc = `CNT_W'(n - 1);
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    pins_d = pins_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - `CNT_W'(1);
    addr_d = addr_q;
    wdata_d = wdata_q;
    drive_d = drive_q;
    rsp_valid_d = 1'b0;
    rsp_data_d = rsp_data_q;
    vpp_on_d = vpp_on_q;
    case (state_q)
      ST_IDLE: begin
        // idle: select high, strobes high, bus released
        // select never pulses, so only the strobes can time a pulse
        pins_d.device_select = 1'b1;
        pins_d.latch_strobe_n = 1'b1;
        pins_d.output_drive_n = 1'b1;
        drive_d = 1'b0;
        if (take_req) begin
          cmd_d = req_cmd_in;
          addr_d = req_addr_in;
          wdata_d = req_data_in;
          if (req_prog) begin
            // skip the voltage wait when it is already up
            pins_d.program_voltage_en = 1'b1;
            vpp_on_d = 1'b1;
            state_d = vpp_on_q ? ST_SETUP : ST_VPP_SETUP;
            cnt_d = vpp_on_q ? cyc(`SETUP_CYC) : cyc(`VPP_SETUP_CYC);
          end else begin
            // reads need normal supply
            pins_d.program_voltage_en = 1'b0;
            vpp_on_d = 1'b0;
            state_d = vpp_on_q ? ST_VPP_SETUP : ST_SETUP;
            cnt_d = vpp_on_q ? cyc(`VPP_SETUP_CYC) : cyc(`SETUP_CYC);
          end
        end else if (drop_vpp) begin
          pins_d.program_voltage_en = 1'b0;
          vpp_on_d = 1'b0;
        end
      end
      ST_VPP_SETUP: begin
        if (cnt_done) begin
          state_d = ST_SETUP;
          cnt_d = cyc(`SETUP_CYC);
        end
      end
      ST_SETUP: begin
        // address and write data settle before the strobe falls
        drive_d = (cmd_q == eeprom_ctl_pkg::CMD_WRITE);
        if (cnt_done) begin
          case (cmd_q)
            eeprom_ctl_pkg::CMD_ERASE: begin
              pins_d.output_drive_n = 1'b0;
              state_d = ST_PULSE;
              cnt_d = cyc(`PULSE_CYC);
            end
            eeprom_ctl_pkg::CMD_WRITE: begin
              pins_d.latch_strobe_n = 1'b0;
              state_d = ST_PULSE;
              cnt_d = cyc(`PULSE_CYC);
            end
            default: begin
              // read: strobe captures address, drive enables outputs
              pins_d.latch_strobe_n = 1'b0;
              pins_d.output_drive_n = 1'b0;
              state_d = ST_ACCESS;
              cnt_d = cyc(`ACCESS_CYC + 2);
            end
          endcase
        end
      end
      ST_PULSE: begin
        // only one strobe is ever low under voltage
        if (cnt_done) begin
          pins_d.latch_strobe_n = 1'b1;
          pins_d.output_drive_n = 1'b1;
          state_d = ST_HOLD;
          cnt_d = cyc(`SETUP_CYC);
        end
      end
      ST_HOLD: begin
        // data and address held past the strobe rise
        if (cnt_done) begin
          drive_d = 1'b0;
          rsp_valid_d = 1'b1;
          state_d = ST_RECOVER;
          cnt_d = cyc(`STROBE_HIGH_CYC);
        end
      end
      ST_ACCESS: begin
        // sampled after access time plus the two sync stages
        if (cnt_done) begin
          rsp_data_d = rd_sync_q;
          rsp_valid_d = 1'b1;
          pins_d.latch_strobe_n = 1'b1;
          pins_d.output_drive_n = 1'b1;
          state_d = ST_RECOVER;
          cnt_d = cyc(`STROBE_HIGH_CYC);
        end
      end
      ST_RECOVER: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_q <= ST_IDLE;
      cmd_q <= eeprom_ctl_pkg::CMD_READ;
      // select low at reset keeps the part deaf
      pins_q <= '{device_select: 1'b0, latch_strobe_n: 1'b1,
                  output_drive_n: 1'b1, program_voltage_en: 1'b0};
      cnt_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      drive_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
      vpp_on_q <= 1'b0;
      ready_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else if (clk_en_in) begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      pins_q <= pins_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      drive_q <= drive_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      vpp_on_q <= vpp_on_d;
      ready_q <= ready_d;
      oe_n_q <= ~drive_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------
  assign req_ready_out = ready_q;
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_data_out = rsp_data_q;
  assign device_select_out = pins_q.device_select;
  assign latch_strobe_n_out = pins_q.latch_strobe_n;
  assign output_drive_n_out = pins_q.output_drive_n;
  assign program_voltage_en_out = pins_q.program_voltage_en;
  assign byte_addr_out = addr_q;
  assign data_out = wdata_q;
  assign data_oe_n_out = oe_n_q;

endmodule
`default_nettype wire

// ==== src/eeprom_ctl_defines.svh ====
// Purpose: constants for the eeprom programming controller
// Assumes: 100 MHz ref_clk_in
// Notes: times kept in their own units, cycle counts derived
`ifndef EEPROM_CTL_DEFINES_SVH
`define EEPROM_CTL_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define ADDR_W 10
`define DATA_W 8
`define MEM_DEPTH 1024
// programming pulse, least 1 ms, most 10 ms
`define PULSE_MIN_US 1000
`define PULSE_CYC ((`PULSE_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// programming voltage set up before a pulse, 5 us
`define VPP_SETUP_US 5
`define VPP_SETUP_CYC ((`VPP_SETUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// address/data set up and hold around strobe, 260 ns
`define SETUP_NS 260
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// read access time, 825 ns worst
`define ACCESS_NS 825
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// strobe high time between accesses, 1.4 us
`define STROBE_HIGH_NS 1400
`define STROBE_HIGH_CYC ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 20
`endif

// ==== src/eeprom_ctl_pkg.sv ====
// Purpose: types for the eeprom programming controller
// Assumes: eeprom_ctl_defines.svh included first
// Notes: command codes and pin bundle
`include "eeprom_ctl_defines.svh"
package eeprom_ctl_pkg;
  typedef enum logic [1:0] {
    CMD_READ,
    CMD_ERASE,
    CMD_WRITE
  } cmd_type;
  typedef struct packed {
    logic device_select;
    logic latch_strobe_n;
    logic output_drive_n;
    logic program_voltage_en;
  } pins_type;
endpackage

// ==== verif/eeprom_ctl_properties.sv ====
// Purpose: pin protocol checks for the eeprom controller
// Assumes: one clock, sync reset
// Notes: pulse bounds 1 to 10 ms
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_ctl_defines.svh"
module eeprom_ctl_checker (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic keep_voltage_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic device_select_out,
  input wire logic latch_strobe_n_out,
  input wire logic output_drive_n_out,
  input wire logic program_voltage_en_out,
  input wire logic [`ADDR_W-1:0] byte_addr_out,
  input wire logic [`DATA_W-1:0] data_out,
  input wire logic data_oe_n_out
);
  // ----
  // helpers
  // ----
  wire logic pulse_on;
  logic [20:0] pcnt_q;
  logic [9:0] vcnt_q;
  assign pulse_on = program_voltage_en_out && !(latch_strobe_n_out && output_drive_n_out);
  // pulse length and supply age; age saturates to stay small
  always_ff @(posedge ref_clk_in) begin
    pcnt_q <= (srst_in || !pulse_on) ? 21'h0_0000 : pcnt_q + 21'h0_0001;
    vcnt_q <= (srst_in || !program_voltage_en_out) ? 10'h000 : vcnt_q + {9'h000, ~&vcnt_q};
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  property p_no_clash;
    program_voltage_en_out |-> latch_strobe_n_out || output_drive_n_out;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both strobes low");
  property p_erase_form;
    $fell(output_drive_n_out) && program_voltage_en_out |-> latch_strobe_n_out;
  endproperty
  a_erase_form: assert property (p_erase_form) else $error("bad erase");
  property p_write_form;
    $fell(latch_strobe_n_out) && program_voltage_en_out |-> output_drive_n_out;
  endproperty
  a_write_form: assert property (p_write_form) else $error("bad write");
  property p_selected;
    !(latch_strobe_n_out && output_drive_n_out) |-> device_select_out;
  endproperty
  a_selected: assert property (p_selected) else $error("strobe unselected");
  property p_bus_free;
    !output_drive_n_out |-> data_oe_n_out;
  endproperty
  a_bus_free: assert property (p_bus_free) else $error("bus clash");
  property p_addr_set;
    $fell(latch_strobe_n_out) |-> $stable(byte_addr_out);
  endproperty
  a_addr_set: assert property (p_addr_set) else $error("address moved");
  property p_data_low;
    program_voltage_en_out && !latch_strobe_n_out |-> !data_oe_n_out && $stable(data_out);
  endproperty
  a_data_low: assert property (p_data_low) else $error("data not held");
  property p_pulse_len;
    !pulse_on && pcnt_q != 21'h0_0000 |-> pcnt_q >= `PULSE_CYC && pcnt_q <= 21'hF_4240;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse width");
  property p_vpp_setup;
    $rose(pulse_on) |-> vcnt_q >= `VPP_SETUP_CYC;
  endproperty
  a_vpp_setup: assert property (p_vpp_setup) else $error("supply setup");
  property p_keep;
    keep_voltage_in && program_voltage_en_out && req_ready_out && !req_valid_in
      |=> program_voltage_en_out;
  endproperty
  a_keep: assert property (p_keep) else $error("supply dropped");
endmodule
bind eeprom_ctl eeprom_ctl_checker chk (
  .ref_clk_in, .srst_in, .keep_voltage_in, .req_valid_in, .req_ready_out,
  .device_select_out, .latch_strobe_n_out, .output_drive_n_out,
  .program_voltage_en_out, .byte_addr_out, .data_out, .data_oe_n_out
);
`default_nettype wire

// ==== verif/eeprom_dev_model.sv ====
// Purpose: behavioural 1024x8 eeprom
// Assumes: pins as the controller drives them
// Notes: preload is addr xor 5a
`timescale 1ns/100ps
`default_nettype none
module eeprom_dev_model #(parameter int ACC_NS = 800) (
  input wire logic sel_in,
  input wire logic strobe_n_in,
  input wire logic drive_n_in,
  input wire logic vpp_in,
  input wire logic [9:0] addr_in,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_en_out
);
  logic [7:0] mem [1024];
  logic [7:0] held;
  logic [9:0] wr_addr;
  wire logic rd_on;
  wire logic rd_late;
  // known pattern so reads before erase can be checked
  initial for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'h5a;
  // address taken at strobe fall, only while selected
  always @(negedge strobe_n_in) begin
    if (sel_in) begin
      held = mem[addr_in];
      wr_addr = addr_in;
    end
  end
  always @(posedge sel_in) if (!strobe_n_in && !vpp_in) held = mem[addr_in];
  // whole array erase on drive pulse with supply up
  always @(negedge drive_n_in) begin
    if (sel_in && vpp_in && strobe_n_in) foreach (mem[i]) mem[i] = 8'h00;
  end
  // data taken at pulse end, so early release shows up as garbage
  always @(posedge strobe_n_in) begin
    if (sel_in && vpp_in && drive_n_in) mem[wr_addr] = mem[wr_addr] | bus_in;
  end
  // select-timed erase and write, for hosts that pulse select instead
  always @(posedge sel_in) begin
    if (vpp_in && strobe_n_in && !drive_n_in) foreach (mem[i]) mem[i] = 8'h00;
    if (vpp_in && !strobe_n_in && drive_n_in) wr_addr = addr_in;
  end
  always @(negedge sel_in) begin
    if (vpp_in && !strobe_n_in && drive_n_in) begin
      mem[wr_addr] = mem[wr_addr] | bus_in;
    end
  end
  assign rd_on = sel_in && !strobe_n_in && !drive_n_in && !vpp_in;
  assign #(ACC_NS) rd_late = rd_on;
  assign bus_en_out = rd_on && rd_late;
  assign bus_out = held;
endmodule
`default_nettype wire

// ==== verif/eeprom_ctl_test.sv ====
// Purpose: self-checking bench for the eeprom controller
// Assumes: 100 MHz clock, full 1 ms pulses
// Notes: reads, erase, chained write, read back
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", nm, e, g); n_fail++; end end
module eeprom_ctl_test;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic req_valid = 1'b0;
  logic keep_v = 1'b0;
  eeprom_ctl_pkg::cmd_type req_cmd = eeprom_ctl_pkg::CMD_READ;
  logic [9:0] req_addr = 10'h000;
  logic [7:0] req_data = 8'h00;
  logic [7:0] float_q = 8'h3c;
  wire logic req_ready, rsp_valid, sel, stb_n, drv_n, vpp, oe_n, dev_en;
  wire logic [9:0] baddr;
  wire logic [7:0] rsp_data, hdata, ddata, bus;
  int n_fail = 0;
  int n_checks = 0;
  logic [8:0] exp_q[$];
  logic [31:0] seed = 32'heda4_3b44;
  always #5 ref_clk_in = ~ref_clk_in;
  // undriven bus shows a changing pattern
  always @(posedge ref_clk_in) float_q <= ~float_q;
  assign bus = dev_en ? ddata : (!oe_n ? hdata : float_q);
  eeprom_ctl DUT (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .clk_en_in(1'b1),
    .req_valid_in(req_valid), .req_cmd_in(req_cmd), .req_addr_in(req_addr),
    .req_data_in(req_data), .keep_voltage_in(keep_v), .req_ready_out(req_ready),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .device_select_out(sel),
    .latch_strobe_n_out(stb_n), .output_drive_n_out(drv_n), .program_voltage_en_out(vpp),
    .byte_addr_out(baddr), .data_in(bus), .data_out(hdata), .data_oe_n_out(oe_n));
  eeprom_dev_model #(.ACC_NS(800)) mem_dev (.sel_in(sel), .strobe_n_in(stb_n),
    .drive_n_in(drv_n), .vpp_in(vpp), .addr_in(baddr), .bus_in(bus),
    .bus_out(ddata), .bus_en_out(dev_en));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test;
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // request held until the edge that sees ready
  task automatic req(input eeprom_ctl_pkg::cmd_type c, input logic [9:0] a,
                     input logic [7:0] d, input logic [8:0] e);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    exp_q.push_back(e);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    req_data <= d;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (req_ready !== 1'b1 && n < 200000);
    req_valid <= 1'b0;
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 200000) begin
      @(posedge ref_clk_in);
      n++;
    end
    repeat (200) @(posedge ref_clk_in);
  endtask
  // oldest note compared against each response when its top bit is set, mid cycle where it has settled
  always @(negedge ref_clk_in) begin
    if (rsp_valid === 1'b1 && exp_q.size() != 0) begin
      if (exp_q[0][8]) `CHK("read byte", exp_q[0][7:0], rsp_data)
      void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (300000) @(posedge ref_clk_in);
    n_fail++;
    stop_test;
  end
  initial begin
    logic [9:0] a;
    logic [7:0] d;
    repeat (4) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    // back to back reads, both ends of the array first
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : seed[9:0];
      req(eeprom_ctl_pkg::CMD_READ, a, seed[17:10], {1'b1, a[7:0] ^ 8'h5a});
    end
    keep_v <= 1'b1;
    req(eeprom_ctl_pkg::CMD_ERASE, 10'h000, 8'h00, 9'h000);
    drain();
    seed = lfsr(seed);
    a = seed[9:0];
    d = seed[17:10] | 8'h81;
    req(eeprom_ctl_pkg::CMD_WRITE, a, d, 9'h000);
    keep_v <= 1'b0;
    req(eeprom_ctl_pkg::CMD_READ, a, 8'h00, {1'b1, d});
    req(eeprom_ctl_pkg::CMD_READ, a ^ 10'h001, 8'h00, 9'h100);
    drain();
    `CHK("pending", 0, exp_q.size())
    stop_test;
  end
endmodule
`default_nettype wire
